// File: test/cpu_core_model.sv
// core-side model: acknowledges requests and returns from service
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic [3:0] irq_source,
  output logic irq_ack,
  output logic irq_return,
  output logic [7:0] served_n
);
  logic [3:0] log_r [0:7];
  logic [3:0] cnt_r;
  logic busy_r;
  // wait two cycles, acknowledge, serve five cycles, return
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq_ack <= 0;
      irq_return <= 0;
      served_n <= 0;
      cnt_r <= 0;
      busy_r <= 0;
    end
    else
    begin
      irq_ack <= 0;
      irq_return <= 0;
      cnt_r <= cnt_r + 4'd1;
      if (busy_r && cnt_r == 4'd4)
      begin
        irq_return <= 1;
        busy_r <= 0;
      end
      else if (!busy_r && !(irq_req && !irq_return && !irq_ack))
        cnt_r <= 0;
      else if (!busy_r && cnt_r == 4'd2)
      begin
        irq_ack <= 1;
        log_r[served_n[2:0]] <= irq_source;
        served_n <= served_n + 8'd1;
        busy_r <= 1;
        cnt_r <= 0;
      end
    end
endmodule // cpu_core_model
`default_nettype wire

// File: test/ext_interrupt_priority_ctrl_tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
`include "irq_defines.vh"
module ext_interrupt_priority_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pin_a, pin_b, stop, e, ce;
  logic pready, pslverr, irq_ack, irq_ret, irq_req, wake_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] irq_source, card;
  logic [1:0] irq_level;
  logic [7:0] pins, hi_sel, lo_sel, served_n, base;
  logic [2:0] bus_ev, misc_ev;
  int n_mismatch, check_count, cyc, k;
  ext_interrupt_priority_ctrl u_ext_interrupt_priority_ctrl (.pclk, .presetn,
    .clk_en(ce), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .multipurpose_user_pins(pins), .user_hi_select(hi_sel),
    .user_lo_select(lo_sel), .dedicated_irq_pin_a(pin_a),
    .dedicated_irq_pin_b(pin_b), .card_events(card),
    .usb_rtc_key_events(bus_ev), .twi_fault_comp_events(misc_ev),
    .timer0_req(1'b0), .timer1_req(1'b0), .serial0_req(1'b0),
    .serial1_req(1'b0), .cpu_stopped(stop), .irq_ack, .irq_return(irq_ret),
    .irq_req, .irq_source, .irq_level, .wake_req);
  cpu_core_model u_cpu_core_model (.pclk, .presetn, .irq_req, .irq_source,
    .irq_ack, .irq_return(irq_ret), .served_n);
  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, then access until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(q, x);
  endtask
  // falling edge on pin a and rising edge on pin b
  task fire;
    pin_a <= 1;
    pin_b <= 0;
    repeat (10) @(posedge pclk);
    pin_a <= 0;
    pin_b <= 1;
    repeat (10) @(posedge pclk);
  endtask
  task serve(input logic [3:0] s0, input logic [3:0] s1);
    base = served_n;
    for (k = 0; k < 300 && served_n != base + 8'd2; k++)
      @(posedge pclk);
    chk(served_n, base + 8'd2);
    chk(u_cpu_core_model.log_r[base[2:0]], s0);
    chk(u_cpu_core_model.log_r[base[2:0] + 3'd1], s1);
  endtask
  initial
  begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done;
    end
  end
  initial
  begin
    {psel, penable, pwrite, stop, presetn} = 0;
    ce = 1;
    {paddr, pwdata, hi_sel, lo_sel, card, bus_ev, misc_ev} = 0;
    {pin_a, pin_b, pins} = 10'h3FF;
    {n_mismatch, check_count, cyc} = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(irq_source, `SRC_NONE);
    rd(`OFS_PRIO_LOW, 0);
    rd(`OFS_PRIO_HIGH, 0);
    rd(`OFS_REQ_FLAGS, 0);
    rd(`OFS_EDGE_CTRL, 0);
    apb(1, 12'h200, 32'h0000_0055);
    chk(e, 1);
    rd(12'h200, 0);
    ce <= 0;
    card[1] <= 1;
    @(posedge pclk);
    ce <= 1;
    card[1] <= 0;
    rd(`OFS_SRC_FLAGS4, 0);
    $display("reset test done");
    apb(1, `OFS_EDGE_CTRL, 32'h0000_0060);
    rd(`OFS_EDGE_CTRL, 32'h0000_0060);
    apb(1, `OFS_EDGE_CTRL, 32'h0000_0040);
    fire;
    chk(irq_req, 0);
    rd(`OFS_REQ_FLAGS, 32'h0000_0006);
    apb(1, `OFS_PRIO_HIGH, 32'h0000_0004);
    apb(1, `OFS_ENABLES, 32'h0000_000C);
    for (k = 0; k < 20 && irq_req !== 1'b1; k++)
      @(posedge pclk);
    chk(irq_level, 2'd2);
    serve(4'd5, 4'd3);
    rd(`OFS_REQ_FLAGS, 0);
    apb(1, `OFS_ENABLES, 0);
    apb(1, `OFS_PRIO_HIGH, 0);
    apb(1, `OFS_PRIO_LOW, 32'h0000_0040);
    rd(`OFS_PRIO_LOW, 32'h0000_0040);
    fire;
    apb(1, `OFS_ENABLES, 32'h0000_000C);
    serve(4'd3, 4'd5);
    apb(1, `OFS_ENABLES, 0);
    $display("edge and priority tests done");
    apb(1, `OFS_SRC_MASKS, 32'h0001_0101);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge pclk);
      {misc_ev[0], bus_ev[0], card[0]} <= 3'b001 << i;
      @(posedge pclk);
      {misc_ev[0], bus_ev[0], card[0]} <= 3'b000;
      repeat (6) @(posedge pclk);
      apb(0, `OFS_SRC_FLAGS4 + 12'd4 * i[11:0], 0);
      k = q[0];
      chk(k, 1);
      rd(`OFS_SRC_FLAGS4 + 12'd4 * i[11:0], 0);
    end
    rd(`OFS_REQ_FLAGS, 32'h0000_0038);
    apb(1, `OFS_REQ_FLAGS, 0);
    rd(`OFS_REQ_FLAGS, 0);
    $display("peripheral test done");
    apb(1, `OFS_ENABLES, 32'h0000_0003);
    hi_sel <= 8'h01;
    lo_sel <= 8'h02;
    stop <= 1;
    pins <= 8'hFC;
    for (k = 0; k < 40 && wake_req !== 1'b1; k++)
      @(posedge pclk);
    chk(wake_req, 1);
    serve(4'd0, 4'd0);
    stop <= 0;
    pins <= 8'hFD;
    repeat (20) @(posedge pclk);
    chk(wake_req, 0);
    serve(4'd4, 4'd4);
    pins <= 8'hFF;
    repeat (30) @(posedge pclk);
    apb(1, `OFS_ENABLES, 0);
    apb(1, `OFS_PIN_TYPE, 32'h0000_0003);
    pins <= 8'hFE;
    repeat (10) @(posedge pclk);
    rd(`OFS_PIN_TYPE, 32'h0000_0007);
    base = served_n;
    apb(1, `OFS_ENABLES, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    chk(served_n, base + 8'd1);
    pins <= 8'hFF;
    $display("user pin test done");
    test_done;
  end
endmodule // ext_interrupt_priority_ctrl_tb
`default_nettype wire

// File: test/irq_ctrl_monitor.sv
// bound checker on the controller's ports
`timescale 1ns/10ps
`default_nettype none
`include "irq_defines.vh"
module irq_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_stopped,
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire logic [3:0] irq_source,
  input wire logic wake_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answer timing and error reporting
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("answer held too long");
  a_err_needs_ready: assert property (pslverr |-> pready)
    else $error("error without answer");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 0)
    else $error("refused read not zero");
  a_unmapped_err: assert property (pready && paddr > `OFS_EDGE_CTRL |-> pslverr)
    else $error("unmapped access accepted");
  a_mapped_no_err: assert property (pready && paddr == `OFS_ENABLES |-> !pslverr)
    else $error("mapped access refused");
  // core handshake and wake
  a_ack_drops_req: assert property (irq_ack |=> !irq_req)
    else $error("request held after ack");
  a_source_in_range: assert property (irq_req |-> irq_source <= 4'hA)
    else $error("bad source code");
  a_wake_needs_stop: assert property (wake_req |-> $past(cpu_stopped))
    else $error("wake while running");
endmodule // irq_ctrl_monitor
bind ext_interrupt_priority_ctrl irq_ctrl_monitor u_irq_ctrl_monitor (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .cpu_stopped, .irq_ack, .irq_req, .irq_source, .wake_req);
`default_nettype wire

// File: verilog/ext_interrupt_priority_ctrl.v
// external interrupt routing, flags and priority resolution
// Functional notes
// [R1] Interrupt 3 pin edge: falling when its select bit is 0, rising when 1.
// [R2] Bit 5 of edge control picks falling or rising edge for interrupt 2.
// [R3] Request flags for interrupts 2..6 sit in bits 1..5; 0,6,7 unused.
// [R4] Maskable sources are ORed onto a line, each with its own flag.
// [R5] User pins drive interrupt 0 (high priority) and 1 (low priority).
// [R6] Two dedicated pins drive interrupts 2 and 3, edge programmable.
// [R7] Peripheral lines for interrupts 4, 5, 6 become rising edges.
// [R8] Card to 4; bus, clock, keypad to 5; serial, fault, comparator to 6.
// [R9] No interrupt reaches the core unless its enable bit is set; timer and serial requests here have no enable bit and pass ungated.
// [R10] Flags set by hardware, cleared automatically when serviced.
// [R11] Reading a per-source flag register of 4..6 clears its flags.
// [R12] Software keeps a copy of the flag register and tests that copy.
// [R13] Interrupt 0 can wake the processor from stop.
// [R14] Six groups: ext0/ser1, t0/ext2, ext1/ext3, t1/ext4, ser0/ext5, ext6.
// [R15] Each group has four levels from one bit in each priority register.
// [R16] Bit 6 of the low priority register is watchdog; bit 7 unused.
// [R17] Equal-level simultaneous requests resolved by fixed polling order.
// [R18] Service pre-empted only by a strictly higher level.
// [R19] Interrupts 0, 1: falling edge when type bit is 1, low level when 0.
// [R20] Level from high bit over low bit: 00 lowest to 11 highest.
// [R21] Poll group 0 first up to 5; left source before right.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "irq_defines.vh"
module ext_interrupt_priority_ctrl #(
  parameter NUM_USER = 8,
  parameter NUM_CARD = 4,
  parameter NUM_BUS = 3,
  parameter NUM_MISC = 3
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NUM_USER-1:0] multipurpose_user_pins,
  input wire [NUM_USER-1:0] user_hi_select,
  input wire [NUM_USER-1:0] user_lo_select,
  input wire dedicated_irq_pin_a,
  input wire dedicated_irq_pin_b,
  input wire [NUM_CARD-1:0] card_events,
  input wire [NUM_BUS-1:0] usb_rtc_key_events,
  input wire [NUM_MISC-1:0] twi_fault_comp_events,
  input wire timer0_req,
  input wire timer1_req,
  input wire serial0_req,
  input wire serial1_req,
  input wire cpu_stopped,
  input wire irq_ack,
  input wire irq_return,
  output reg irq_req,
  output reg [3:0] irq_source,
  output reg [1:0] irq_level,
  output reg wake_req
);
  // source numbers in polling order
  localparam [3:0] S_EXT0 = 4'h0, S_SER1 = 4'h1, S_TMR0 = 4'h2;
  localparam [3:0] S_EXT2 = 4'h3, S_EXT1 = 4'h4, S_EXT3 = 4'h5;
  localparam [3:0] S_TMR1 = 4'h6, S_EXT4 = 4'h7, S_SER0 = 4'h8;
  localparam [3:0] S_EXT5 = 4'h9, S_EXT6 = 4'hA;

  // group level from both priority bits, high over low
  function [1:0] grp_level;
    input [5:0] lo;
    input [5:0] hi;
    input [2:0] g;
    begin
      grp_level = {hi[g], lo[g]}; // [R20]
    end
  endfunction

  // group index of each source
  function [2:0] grp_of;
    input [3:0] s;
    begin
      grp_of = s[3:1];
      if (s == S_EXT6)
        grp_of = 3'd5;
    end
  endfunction

  // configuration registers
  reg [7:0] prio_lo_r;
  reg [5:0] prio_hi_r;
  reg [1:0] edge_sel_r;
  reg [6:0] enables_r;
  reg [1:0] pin_type_r;
  // request flags
  reg [1:0] flag01_r;
  reg [4:0] flag26_r;
  // per-source flags and their masks
  reg [NUM_CARD-1:0] src4_r;
  reg [NUM_BUS-1:0] src5_r;
  reg [NUM_MISC-1:0] src6_r;
  reg [NUM_CARD-1:0] mask4_r;
  reg [NUM_BUS-1:0] mask5_r;
  reg [NUM_MISC-1:0] mask6_r;
  // history for edge detection
  reg [4:0] prev_r;
  reg [2:0] peri_prev_r;
  // service stack: depth and the level of each nested service
  reg [3:0] act_cnt_r;
  reg [1:0] act_lvl_r [0:3];
  // arbitration results
  reg [3:0] win_src;
  reg [1:0] win_lvl;
  reg win_ok;
  reg [10:0] pend;
  reg [1:0] lvl;
  integer i;
  integer j;

  wire [4:0] sync_out;
  wire [4:0] sync_stable;
  wire user_hi = |(~multipurpose_user_pins & user_hi_select);
  wire user_lo = |(~multipurpose_user_pins & user_lo_select);

  // pins pass three flops; a change counts when stages two and three agree
  sync3 #(.W(5)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    // user lines enter inverted so that their idle level is the reset level
    .din({dedicated_irq_pin_b, dedicated_irq_pin_a, ~user_lo, ~user_hi,
      multipurpose_user_pins[0]}),
    .dout(sync_out),
    .stable(sync_stable)
  );

  // user pins low-active: hi select to ext0, lo select to ext1
  wire lvl0 = ~sync_out[1] & sync_stable[1]; // [R5]
  wire lvl1 = ~sync_out[2] & sync_stable[2]; // [R5]
  wire pin2 = sync_out[3];
  wire pin3 = sync_out[4];
  wire [4:0] cur = {pin3, pin2, lvl1, lvl0, 1'b0};

  // edge or level events for the pin-driven lines
  wire fall0 = ~prev_r[1] & lvl0;
  wire fall1 = ~prev_r[2] & lvl1;
  wire ev0 = pin_type_r[0] ? fall0 : lvl0; // [R19]
  wire ev1 = pin_type_r[1] ? fall1 : lvl1; // [R19]
  wire ev2 = sync_stable[3] & (edge_sel_r[0] ? ~prev_r[3] & pin2
    : prev_r[3] & ~pin2); // [R2] [R6]
  wire ev3 = sync_stable[4] & (edge_sel_r[1] ? ~prev_r[4] & pin3
    : prev_r[4] & ~pin3); // [R1] [R6]

  // per-source flags ORed onto the peripheral lines
  wire line4 = |(src4_r & mask4_r); // [R4] [R8]
  wire line5 = |(src5_r & mask5_r); // [R4] [R8]
  wire line6 = |(src6_r & mask6_r); // [R4] [R8]
  wire ev4 = line4 & ~peri_prev_r[0]; // [R7]
  wire ev5 = line5 & ~peri_prev_r[1]; // [R7]
  wire ev6 = line6 & ~peri_prev_r[2]; // [R7]

  // transfer strobes; a transfer completes when pready stands in access
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire wr_done = wr & pready;
  wire rd_done = rd & pready;
  wire ack_ext = irq_ack & irq_req;
  wire [1:0] cur_lvl = act_lvl_r[act_cnt_r[1:0] - 2'd1];
  // decode of mapped addresses; anything else is answered with an error
  wire known = (paddr == `OFS_PRIO_LOW) || (paddr == `OFS_REQ_FLAGS) ||
    (paddr == `OFS_EDGE_CTRL) || (paddr == `OFS_PRIO_HIGH) ||
    (paddr == `OFS_ENABLES) || (paddr == `OFS_PIN_TYPE) ||
    (paddr == `OFS_STATUS) || (paddr == `OFS_SERVICE) ||
    (paddr == `OFS_SRC_FLAGS4) || (paddr == `OFS_SRC_FLAGS5) ||
    (paddr == `OFS_SRC_FLAGS6) || (paddr == `OFS_SRC_MASKS);

  // pending vector in polling order, enables gate each external source
  always @*
  begin
    pend = 11'd0;
    pend[S_EXT0] = flag01_r[0] & enables_r[0]; // [R9]
    pend[S_EXT1] = flag01_r[1] & enables_r[1]; // [R9]
    pend[S_EXT2] = flag26_r[0] & enables_r[2]; // [R9]
    pend[S_EXT3] = flag26_r[1] & enables_r[3]; // [R9]
    pend[S_EXT4] = flag26_r[2] & enables_r[4]; // [R9]
    pend[S_EXT5] = flag26_r[3] & enables_r[5]; // [R9]
    pend[S_EXT6] = flag26_r[4] & enables_r[6]; // [R9]
    pend[S_SER1] = serial1_req;
    pend[S_TMR0] = timer0_req;
    pend[S_TMR1] = timer1_req;
    pend[S_SER0] = serial0_req;
  end

  // highest level wins; first in polling order breaks ties
  always @*
  begin
    win_src = `SRC_NONE;
    win_lvl = 2'd0;
    win_ok = 1'b0;
    lvl = 2'd0;
    for (i = 10; i >= 0; i = i - 1)
    begin
      lvl = grp_level(prio_lo_r[5:0], prio_hi_r, grp_of(i[3:0])); // [R15]
      if (pend[i] && (!win_ok || lvl >= win_lvl)) // [R17] [R21] [R14]
      begin
        win_ok = 1'b1;
        win_lvl = lvl;
        win_src = i[3:0];
      end
    end
  end

  // preemption needs strictly higher level than the one in service
  wire may_take = win_ok && (act_cnt_r == 4'd0 ||
    win_lvl > cur_lvl); // [R18]

  // registers, flags, service stack
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prio_lo_r <= `RST_BYTE;
      prio_hi_r <= `RST_PRIO;
      edge_sel_r <= 2'b00;
      enables_r <= `RST_ENABLES;
      pin_type_r <= 2'b00;
      flag01_r <= 2'b00;
      flag26_r <= 5'd0;
      src4_r <= {NUM_CARD{1'b0}};
      src5_r <= {NUM_BUS{1'b0}};
      src6_r <= {NUM_MISC{1'b0}};
      mask4_r <= {NUM_CARD{1'b0}};
      mask5_r <= {NUM_BUS{1'b0}};
      mask6_r <= {NUM_MISC{1'b0}};
      // pin history starts at the idle level of each line: dedicated pins high, user lines low
      prev_r <= 5'h18;
      peri_prev_r <= 3'd0;
      act_cnt_r <= 4'd0;
      for (j = 0; j < 4; j = j + 1)
        act_lvl_r[j] <= 2'd0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_req <= 1'b0;
      irq_source <= `SRC_NONE;
      irq_level <= 2'd0;
      wake_req <= 1'b0;
    end
    else if (clk_en)
    begin
      // edge history, and the answer one cycle after setup
      prev_r <= cur;
      peri_prev_r <= {line6, line5, line4};
      pready <= setup;
      pslverr <= setup & ~known;
      prdata <= 32'h0000_0000;
      // register writes
      if (wr_done)
      begin
        case (paddr)
          `OFS_PRIO_LOW: prio_lo_r <= {1'b0, pwdata[6:0]}; // [R16]
          `OFS_PRIO_HIGH: prio_hi_r <= pwdata[5:0];
          `OFS_EDGE_CTRL: edge_sel_r <= {pwdata[`BIT_IRQ3_EDGE],
            pwdata[`BIT_IRQ2_EDGE]};
          `OFS_ENABLES: enables_r <= pwdata[6:0];
          `OFS_PIN_TYPE: pin_type_r <= pwdata[1:0];
          `OFS_SRC_MASKS:
          begin
            mask4_r <= pwdata[NUM_CARD-1:0];
            mask5_r <= pwdata[8+NUM_BUS-1:8];
            mask6_r <= pwdata[16+NUM_MISC-1:16];
          end
          default: ;
        endcase
      end
      // software write to request flags, then hardware sets win
      if (wr_done && paddr == `OFS_REQ_FLAGS)
        flag26_r <= pwdata[5:1];
      if (ack_ext && irq_source == S_EXT2) flag26_r[0] <= 1'b0; // [R10]
      if (ack_ext && irq_source == S_EXT3) flag26_r[1] <= 1'b0; // [R10]
      if (ack_ext && irq_source == S_EXT4) flag26_r[2] <= 1'b0; // [R10]
      if (ack_ext && irq_source == S_EXT5) flag26_r[3] <= 1'b0; // [R10]
      if (ack_ext && irq_source == S_EXT6) flag26_r[4] <= 1'b0; // [R10]
      if (ack_ext && irq_source == S_EXT0) flag01_r[0] <= 1'b0; // [R10]
      if (ack_ext && irq_source == S_EXT1) flag01_r[1] <= 1'b0; // [R10]
      if (ev0) flag01_r[0] <= 1'b1; // [R10]
      if (ev1) flag01_r[1] <= 1'b1; // [R10]
      if (ev2) flag26_r[0] <= 1'b1; // [R3] [R10]
      if (ev3) flag26_r[1] <= 1'b1; // [R3]
      if (ev4) flag26_r[2] <= 1'b1; // [R3]
      if (ev5) flag26_r[3] <= 1'b1; // [R3]
      if (ev6) flag26_r[4] <= 1'b1; // [R3]
      // per-source flags: read clears, new event in same cycle stays
      src4_r <= ((rd_done && paddr == `OFS_SRC_FLAGS4) ?
        {NUM_CARD{1'b0}} : src4_r) | card_events; // [R11]
      src5_r <= ((rd_done && paddr == `OFS_SRC_FLAGS5) ?
        {NUM_BUS{1'b0}} : src5_r) | usb_rtc_key_events; // [R11]
      src6_r <= ((rd_done && paddr == `OFS_SRC_FLAGS6) ?
        {NUM_MISC{1'b0}} : src6_r) | twi_fault_comp_events; // [R11]
      // read data
      if (setup)
      begin
        case (paddr)
          `OFS_PRIO_LOW: prdata[7:0] <= prio_lo_r;
          `OFS_PRIO_HIGH: prdata[5:0] <= prio_hi_r;
          `OFS_REQ_FLAGS: prdata[5:1] <= flag26_r;
          `OFS_EDGE_CTRL: prdata[6:5] <= edge_sel_r;
          `OFS_ENABLES: prdata[6:0] <= enables_r;
          `OFS_PIN_TYPE: prdata[3:0] <= {flag01_r, pin_type_r};
          `OFS_STATUS: prdata[7:0] <= {act_cnt_r, win_src};
          `OFS_SRC_FLAGS4: prdata[NUM_CARD-1:0] <= src4_r;
          `OFS_SRC_FLAGS5: prdata[NUM_BUS-1:0] <= src5_r;
          `OFS_SRC_FLAGS6: prdata[NUM_MISC-1:0] <= src6_r;
          `OFS_SRC_MASKS:
          begin
            prdata[NUM_CARD-1:0] <= mask4_r;
            prdata[8+NUM_BUS-1:8] <= mask5_r;
            prdata[16+NUM_MISC-1:16] <= mask6_r;
          end
          default: ;
        endcase
      end
      // service stack: push on acknowledge, pop on return
      // four levels with strict pre-emption never nest deeper than four
      if (ack_ext && act_cnt_r < 4'd4)
      begin
        act_lvl_r[act_cnt_r[1:0]] <= irq_level;
        act_cnt_r <= act_cnt_r + 4'd1;
      end
      else if (irq_return && act_cnt_r != 4'd0)
        act_cnt_r <= act_cnt_r - 4'd1;
      // request outputs to the core
      // the level shown beside the source is what gets pushed on acknowledge
      irq_req <= may_take & ~ack_ext;
      irq_source <= may_take ? win_src : `SRC_NONE;
      irq_level <= win_lvl;
      wake_req <= cpu_stopped & (fall0 | lvl0) & enables_r[0]; // [R13]
    end
  end
endmodule // ext_interrupt_priority_ctrl
`default_nettype wire

// File: verilog/irq_defines.vh
// register offsets, field positions and reset values
`ifndef IRQ_DEFINES_VH
`define IRQ_DEFINES_VH
// the core's register numbers are word indices; byte address is four times
`define IDX_PRIO_LOW 10'h0A9
`define IDX_REQ_FLAGS 10'h0C0
`define IDX_EDGE_CTRL 10'h0C8
`define IDX_PRIO_HIGH 10'h0B9
`define OFS_PRIO_LOW {`IDX_PRIO_LOW, 2'b00}
`define OFS_REQ_FLAGS {`IDX_REQ_FLAGS, 2'b00}
`define OFS_EDGE_CTRL {`IDX_EDGE_CTRL, 2'b00}
`define OFS_PRIO_HIGH {`IDX_PRIO_HIGH, 2'b00}
// own registers, byte addresses
`define OFS_ENABLES 12'h100
`define OFS_PIN_TYPE 12'h104
`define OFS_STATUS 12'h108
`define OFS_SERVICE 12'h10C
`define OFS_SRC_FLAGS4 12'h110
`define OFS_SRC_FLAGS5 12'h114
`define OFS_SRC_FLAGS6 12'h118
`define OFS_SRC_MASKS 12'h11C
// field positions
`define BIT_IRQ3_EDGE 6
`define BIT_IRQ2_EDGE 5
`define BIT_WDOG_SIDE 6
// reset values
`define RST_BYTE 8'h00
`define RST_PRIO 6'h00
`define RST_ENABLES 7'h00
// a source number of eleven sources, and the "none" code
`define SRC_NONE 4'hF
`endif

// File: verilog/sync3.v
// three-flop input synchroniser for pin-level signals
`timescale 1ns/10ps
`default_nettype none
module sync3 #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire [W-1:0] din,
  output wire [W-1:0] dout,
  output wire [W-1:0] stable
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  // shift chain; only the second stage reads the first
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= {W{1'b1}};
      s2_r <= {W{1'b1}};
      s3_r <= {W{1'b1}};
    end
    else if (clk_en)
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign dout = s3_r;
  assign stable = ~(s2_r ^ s3_r);
endmodule // sync3
`default_nettype wire
